// *** mds_pkg.sv ***
// Constants and types shared by the data-memory and status core.
// Assumes one 8-bit data space and a 16-bit program word.
package mds_pkg;
  // ****************************************
  // Data memory map
  // ****************************************
  localparam logic [7:0] ADDR_WIN0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_WIN1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_ACC = 8'h05;
  localparam logic [7:0] ADDR_TABLE_POINTER = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0a;
  localparam logic [7:0] GPR_BASE = 8'h80;
  localparam logic [7:0] DISP_BASE = 8'h40;
  localparam int GPR_WORDS = 96;
  localparam int DISP_WORDS = 21;
  localparam int PAGE_BITS = 8;
  localparam int PC_BITS = 11;
  localparam logic [7:0] READ_NONE = 8'h00;

  // ****************************************
  // Status field positions and reset values
  // ****************************************
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_FLAG = 1'b0;
  localparam int TBL_CYCLES = 2;

  // ****************************************
  // Commands from the execution unit
  // ****************************************
  typedef enum logic [2:0] {OP_RD, OP_WR, OP_ALU, OP_BSET, OP_BCLR, OP_TRC,
    OP_TRL, OP_SYS} mds_op_e;
  typedef enum logic [3:0] {FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_AND, FN_OR,
    FN_XOR, FN_CPL, FN_INC, FN_DEC, FN_RRC, FN_RLC, FN_KICK, FN_HALT} mds_fn_e;
endpackage

// *** mds_mem_if.sv ***
// Port bundle between the core and its general and display RAM.
// Assumes asynchronous read and write on the rising clock.
`timescale 1ns/1ps
`default_nettype none
interface mds_mem_if #(parameter int AW = 7);
  logic [AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** mds_ram.sv ***
// General-purpose and display data memory in one array.
// Assumes the core resolves addresses and blocks unmapped writes.
`timescale 1ns/1ps
`default_nettype none
module mds_ram #(
  parameter int WORDS = 117,
  parameter int AW = 7
) (
  input wire logic sys_clk,
  mds_mem_if.mem port
);
  logic [7:0] mem_r [WORDS];

  // Read is combinational so a read-modify-write fits one cycle
  assign port.rdata = (32'(port.addr) < WORDS) ? mem_r[port.addr] : 8'h00;

  // Contents are not cleared by reset, like a real RAM
  always_ff @(posedge sys_clk)
  begin
    if (port.we && (32'(port.addr) < WORDS))
    begin
      mem_r[port.addr] <= port.wdata;
    end
  end
endmodule
`default_nettype wire

// *** mds_alu.sv ***
// Eight-bit ALU with carry, nibble carry and signed wrap; the core derives zero.
// Assumes a is the accumulator and b the memory or immediate operand.
`timescale 1ns/1ps
`default_nettype none
module mds_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire mds_pkg::mds_fn_e fn,
  output logic [7:0] res,
  output logic c_out,
  output logic ac_out,
  output logic ov_out,
  output logic upd_arith,
  output logic upd_c
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] low7;
  logic [7:0] y;
  logic ci;

  // Subtraction is a + ~b + ci, so carry means no borrow
  always_comb
  begin
    y = b;
    ci = 1'b0;
    case (fn)
      mds_pkg::FN_ADC: ci = cin;
      mds_pkg::FN_SUB:
      begin
        y = ~b;
        ci = 1'b1;
      end
      mds_pkg::FN_SBC:
      begin
        y = ~b;
        ci = cin;
      end
      default: ci = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, y} + {8'h00, ci};
    lo = {1'b0, a[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    low7 = {1'b0, a[6:0]} + {1'b0, y[6:0]} + {7'h00, ci};
    res = sum[7:0];
    c_out = sum[8]; // RL15
    ac_out = lo[4]; // RL16
    ov_out = low7[7] ^ sum[8]; // RL18
    upd_arith = 1'b1;
    upd_c = 1'b0;
    case (fn)
      mds_pkg::FN_AND: res = a & b;
      mds_pkg::FN_OR: res = a | b;
      mds_pkg::FN_XOR: res = a ^ b;
      mds_pkg::FN_CPL: res = ~b;
      mds_pkg::FN_INC: res = b + 8'h01;
      mds_pkg::FN_DEC: res = b - 8'h01;
      mds_pkg::FN_RRC:
      begin
        res = {cin, b[7:1]};
        c_out = b[0]; // RL15
        upd_c = 1'b1;
      end
      mds_pkg::FN_RLC:
      begin
        res = {b[6:0], cin};
        c_out = b[7]; // RL15
        upd_c = 1'b1;
      end
      default: res = sum[7:0];
    endcase
    if (fn > mds_pkg::FN_SBC)
    begin
      upd_arith = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** mds_core.sv ***
// Data memory, pointers, accumulator, table read and status core.
// Assumes the execution unit issues one command at a time and the
// program ROM answers in the same clock that prog_rd_r is high.
//
// How it works
// (RL1) Current-page table address is upper PC bits above 7 plus the pointer.
// (RL2) Last-page table address forces all bits above 7 to one.
// (RL3) Table read puts low byte at the target, high byte in 08H.
// (RL4) Table pointer at 07H is read/write and selects the table word.
// (RL5) Each table read takes two cycles to finish.
// (RL6) Software masks interrupts around table reads until high byte is saved.
// (RL7) Unused registers below 80H read as zero.
// (RL8) General RAM sits from 80H up, 48 or 96 bytes per variant.
// (RL9) Bit set and clear plus ALU operations work on any data location.
// (RL10) Addresses 00H and 02H go through pointers at 01H and 03H.
// (RL11) A pointer aimed at a window reads zero and ignores writes.
// (RL12) Pointers are 8 bits; only pointer one reaches display memory.
// (RL13) Accumulator at 05H takes ALU results and carries memory moves.
// (RL14) Status writes keep the watchdog flags; bits 7 and 6 read zero.
// (RL15) Carry follows add carry, subtract no-borrow and rotates.
// (RL16) Nibble carry follows the low nibble carry or no-borrow.
// (RL17) Zero flag is set for a zero arithmetic or logic result.
// (RL18) Signed wrap is carry into bit 7 xor carry out.
// (RL19) Sleep flag clears on power-up or kick, sets on halt.
// (RL20) Expiry flag clears on power-up, kick or halt, sets on time-out.
// (RL21) Neither calls nor interrupts save the status register.
// (RL22) With watchdog off its commands do nothing; on, it wakes from sleep.
`timescale 1ns/1ps
`default_nettype none
module mds_core #(
  parameter int GPR_WORDS = mds_pkg::GPR_WORDS,
  parameter int PC_W = mds_pkg::PC_BITS,
  parameter bit WDT_EN = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire mds_pkg::mds_op_e cmd_op,
  input wire mds_pkg::mds_fn_e cmd_fn,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_imm,
  input wire logic cmd_to_acc,
  input wire logic [PC_W-1:0] pc_now,
  input wire logic [15:0] prog_data,
  input wire logic wdt_timeout,
  output logic cmd_ready_r,
  output logic rsp_valid_r,
  output logic [7:0] rsp_data_r,
  output logic prog_rd_r,
  output logic [PC_W-1:0] prog_addr_r,
  output logic [7:0] acc_r,
  output logic [7:0] status_r,
  output logic power_down_r,
  output logic wdt_wake_r,
  output logic wdt_reset_r
);
  localparam int WORDS = GPR_WORDS + mds_pkg::DISP_WORDS;
  localparam int AW = 7;
  localparam logic [7:0] GPR_TOP = 8'(32'(mds_pkg::GPR_BASE) + GPR_WORDS);
  localparam logic [7:0] DISP_TOP = 8'(32'(mds_pkg::DISP_BASE) + mds_pkg::DISP_WORDS);

  typedef enum logic {S_IDLE, S_TBL} mds_st_e;
  typedef struct packed {
    mds_st_e st;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] acc;
    logic [7:0] table_pointer;
    logic [7:0] table_high_byte;
    logic [7:0] dest;
    logic c, ac, z, ov, sleep_entered_flag, to, pd;
    logic ready, rsp_valid, prog_rd, wake, wreset;
    logic [7:0] rsp_data;
    logic [PC_W-1:0] prog_addr;
  } mds_state_s;

  mds_state_s q, n;
  mds_mem_if #(.AW(AW)) mem ();
  logic [7:0] eff_addr, phys, rval, wr_val, alu_b, alu_res;
  logic ok, via1, gpr_hit, disp_hit, wr_en, acc_op;
  logic alu_c, alu_ac, alu_ov, alu_arith, alu_updc;

  // ****************************************
  // Sub-blocks
  // ****************************************
  mds_ram #(.WORDS(WORDS), .AW(AW)) u_ram (
    .sys_clk(sys_clk),
    .port(mem.mem)
  );

  mds_alu u_alu (
    .a(q.acc), // RL13
    .b(alu_b),
    .cin(q.c),
    .fn(cmd_fn),
    .res(alu_res),
    .c_out(alu_c),
    .ac_out(alu_ac),
    .ov_out(alu_ov),
    .upd_arith(alu_arith),
    .upd_c(alu_updc)
  );

  // ****************************************
  // Address resolution and read mux
  // ****************************************
  // Windows redirect through their pointer; a pointer aimed at a window is
  // refused, which also blocks window-to-window moves
  always_comb
  begin
    eff_addr = (q.st == S_TBL) ? q.dest : cmd_addr;
    via1 = (eff_addr == mds_pkg::ADDR_WIN1);
    phys = (eff_addr == mds_pkg::ADDR_WIN0) ? q.ptr0 : via1 ? q.ptr1 : eff_addr; // RL10
    ok = 1'b1;
    if ((eff_addr == mds_pkg::ADDR_WIN0 || eff_addr == mds_pkg::ADDR_WIN1) &&
        (phys == mds_pkg::ADDR_WIN0 || phys == mds_pkg::ADDR_WIN1))
    begin
      ok = 1'b0; // RL11
    end
    gpr_hit = ok && phys >= mds_pkg::GPR_BASE && phys < GPR_TOP; // RL8
    // Display memory answers only through pointer one
    disp_hit = ok && via1 && phys >= mds_pkg::DISP_BASE && phys < DISP_TOP; // RL12
    mem.addr = gpr_hit ? AW'(phys - mds_pkg::GPR_BASE)
      : AW'(32'(phys - mds_pkg::DISP_BASE) + GPR_WORDS);
    rval = mds_pkg::READ_NONE; // RL7
    if (gpr_hit || disp_hit)
    begin
      rval = mem.rdata;
    end
    else if (ok)
    begin
      case (phys)
        mds_pkg::ADDR_PTR0: rval = q.ptr0;
        mds_pkg::ADDR_PTR1: rval = q.ptr1;
        mds_pkg::ADDR_ACC: rval = q.acc;
        mds_pkg::ADDR_TABLE_POINTER: rval = q.table_pointer; // RL4
        mds_pkg::ADDR_TABLE_HIGH_BYTE: rval = q.table_high_byte;
        mds_pkg::ADDR_STAT: rval = status_r; // RL14
        default: rval = mds_pkg::READ_NONE; // RL7
      endcase
    end
    alu_b = cmd_imm ? cmd_data : rval;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  // Stack pushes live elsewhere; nothing here copies status on a call
  always_comb
  begin
    n = q; // RL21
    n.rsp_valid = 1'b0;
    n.prog_rd = 1'b0;
    n.wake = 1'b0;
    n.wreset = 1'b0;
    wr_en = 1'b0;
    wr_val = rval;
    acc_op = 1'b0;
    case (q.st)
      S_IDLE:
      begin
        if (cmd_valid && q.ready)
        begin
          n.pd = 1'b0;
          case (cmd_op)
            mds_pkg::OP_RD:
            begin
              n.rsp_data = rval;
              n.rsp_valid = 1'b1;
            end
            mds_pkg::OP_WR:
            begin
              wr_en = 1'b1;
              wr_val = cmd_data;
            end
            mds_pkg::OP_ALU:
            begin
              acc_op = 1'b1;
              wr_en = !cmd_to_acc; // RL9
              wr_val = alu_res;
            end
            mds_pkg::OP_BSET:
            begin
              wr_en = 1'b1; // RL9
              wr_val = rval | (8'h01 << cmd_data[2:0]);
            end
            mds_pkg::OP_BCLR:
            begin
              wr_en = 1'b1; // RL9
              wr_val = rval & ~(8'h01 << cmd_data[2:0]);
            end
            mds_pkg::OP_TRC, mds_pkg::OP_TRL:
            begin
              n.prog_addr = {pc_now[PC_W-1:mds_pkg::PAGE_BITS], q.table_pointer}; // RL1
              if (cmd_op == mds_pkg::OP_TRL)
              begin
                n.prog_addr[PC_W-1:mds_pkg::PAGE_BITS] = '1; // RL2
              end
              n.prog_rd = 1'b1;
              n.dest = cmd_addr;
              n.ready = 1'b0; // RL5
              n.st = S_TBL;
            end
            default:
            begin
              if (cmd_fn == mds_pkg::FN_KICK && WDT_EN) // RL22
              begin
                n.sleep_entered_flag = 1'b0; // RL19
                n.to = 1'b0; // RL20
              end
              else if (cmd_fn == mds_pkg::FN_HALT)
              begin
                n.sleep_entered_flag = 1'b1; // RL19
                n.to = 1'b0; // RL20
                n.pd = 1'b1;
              end
            end
          endcase
        end
      end
      S_TBL:
      begin
        // ROM word arrives now; finishing here makes the second cycle
        wr_en = 1'b1;
        wr_val = prog_data[7:0]; // RL3
        n.table_high_byte = prog_data[15:8]; // RL3
        n.rsp_data = prog_data[7:0];
        n.rsp_valid = 1'b1;
        n.ready = 1'b1; // RL5
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase

    // Store; refused windows fall through as no-ops
    mem.we = wr_en && (gpr_hit || disp_hit); // RL11
    mem.wdata = wr_val;
    if (wr_en && ok && !gpr_hit && !disp_hit)
    begin
      case (phys)
        mds_pkg::ADDR_PTR0: n.ptr0 = wr_val;
        mds_pkg::ADDR_PTR1: n.ptr1 = wr_val;
        mds_pkg::ADDR_ACC: n.acc = wr_val;
        mds_pkg::ADDR_TABLE_POINTER: n.table_pointer = wr_val; // RL4
        mds_pkg::ADDR_STAT:
        begin
          n.c = wr_val[mds_pkg::ST_C]; // RL14
          n.ac = wr_val[mds_pkg::ST_AC];
          n.z = wr_val[mds_pkg::ST_Z];
          n.ov = wr_val[mds_pkg::ST_OV];
        end
        default: n.ptr0 = n.ptr0; // RL7
      endcase
    end

    // Flags from the ALU win over a store into status
    if (acc_op)
    begin
      if (cmd_to_acc)
      begin
        n.acc = alu_res; // RL13
      end
      if (!alu_updc)
      begin
        n.z = (alu_res == 8'h00); // RL17
      end
      if (alu_arith || alu_updc)
      begin
        n.c = alu_c; // RL15
      end
      if (alu_arith)
      begin
        n.ac = alu_ac; // RL16
        n.ov = alu_ov; // RL18
      end
    end

    // Time-out last, so it wins over a kick in the same cycle
    if (wdt_timeout && WDT_EN)
    begin
      n.to = 1'b1; // RL20
      if (q.pd)
      begin
        n.wake = 1'b1; // RL22
        n.pd = 1'b0;
      end
      else
      begin
        n.wreset = 1'b1;
      end
    end
  end

  // ****************************************
  // State register and outputs
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.ready <= 1'b1;
      q.sleep_entered_flag <= mds_pkg::RST_FLAG; // RL19
      q.to <= mds_pkg::RST_FLAG; // RL20
    end
    else
    begin
      q <= n;
    end
  end

  assign cmd_ready_r = q.ready;
  assign rsp_valid_r = q.rsp_valid;
  assign rsp_data_r = q.rsp_data;
  assign prog_rd_r = q.prog_rd;
  assign prog_addr_r = q.prog_addr;
  assign acc_r = q.acc;
  assign status_r = {2'b00, q.to, q.sleep_entered_flag, q.ov, q.z, q.ac, q.c}; // RL14
  assign power_down_r = q.pd;
  assign wdt_wake_r = q.wake;
  assign wdt_reset_r = q.wreset;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  assign take = cmd_valid && q.ready && q.st == S_IDLE;

  tbl_two_cycle_a: assert property (take && (cmd_op == mds_pkg::OP_TRC ||
      cmd_op == mds_pkg::OP_TRL) |=> !cmd_ready_r && !rsp_valid_r ##1
      cmd_ready_r && rsp_valid_r) else $error("table read not two cycles"); // RL5
  last_page_a: assert property (take && cmd_op == mds_pkg::OP_TRL |=>
      prog_rd_r && &prog_addr_r[PC_W-1:8] && prog_addr_r[7:0] == $past(q.table_pointer))
      else $error("last page address wrong"); // RL2
  cur_page_a: assert property (take && cmd_op == mds_pkg::OP_TRC |=>
      prog_addr_r == {$past(pc_now[PC_W-1:8]), $past(q.table_pointer)})
      else $error("current page address wrong"); // RL1
  table_high_byte_load_a: assert property (q.st == S_TBL |=> q.table_high_byte == $past(prog_data[15:8])
      && rsp_data_r == $past(prog_data[7:0])) else $error("table bytes wrong"); // RL3
  status_guard_a: assert property (take && cmd_op == mds_pkg::OP_WR &&
      cmd_addr == mds_pkg::ADDR_STAT && !wdt_timeout |=> $stable(status_r[5:4])
      && status_r[7:6] == 2'b00) else $error("status write hit guarded bits"); // RL14
  kick_clear_a: assert property (WDT_EN && take && cmd_op == mds_pkg::OP_SYS &&
      cmd_fn == mds_pkg::FN_KICK && !wdt_timeout |=> status_r[5:4] == 2'b00)
      else $error("kick left flags set"); // RL19
  halt_flag_a: assert property (take && cmd_op == mds_pkg::OP_SYS &&
      cmd_fn == mds_pkg::FN_HALT && !wdt_timeout |=> status_r[5:4] == 2'b01 &&
      power_down_r) else $error("halt flags wrong"); // RL20
  wake_pulse_a: assert property (WDT_EN && power_down_r && wdt_timeout |=>
      wdt_wake_r && status_r[5] && !power_down_r ##1 !wdt_wake_r)
      else $error("no wake on time-out"); // RL22
  reserved_zero_a: assert property (take && cmd_op == mds_pkg::OP_RD &&
      cmd_addr > mds_pkg::ADDR_STAT && cmd_addr < mds_pkg::GPR_BASE |=>
      rsp_valid_r && rsp_data_r == 8'h00) else $error("reserved read not zero"); // RL7
  self_window_a: assert property (take && cmd_op == mds_pkg::OP_RD &&
      cmd_addr == mds_pkg::ADDR_WIN0 && q.ptr0 <= mds_pkg::ADDR_WIN1 && !q.ptr0[0]
      |=> rsp_data_r == 8'h00) else $error("window loop read not zero"); // RL11

  tbl_done_c: cover property (q.st == S_TBL ##1 rsp_valid_r);
  halt_wake_c: cover property (power_down_r ##[1:20] wdt_wake_r);
  alu_mem_c: cover property (take && cmd_op == mds_pkg::OP_ALU && !cmd_to_acc);
endmodule
`default_nettype wire

// *** mds_core_tb.sv ***
// Self-checking bench for the data-memory and status core.
// Assumes mds_pkg, mds_mem_if, mds_ram, mds_alu and mds_core compile first.
`timescale 1ns/1ps
`default_nettype none
module mds_core_tb;
  // ****************************************
  // Stimulus, design and result notes
  // ****************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  mds_pkg::mds_op_e cmd_op = mds_pkg::OP_RD;
  mds_pkg::mds_fn_e cmd_fn = mds_pkg::FN_ADD;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_imm = 1'b0;
  logic cmd_to_acc = 1'b0;
  logic [10:0] pc_now = 11'h000;
  logic [15:0] prog_data = 16'h0000;
  logic wdt_timeout = 1'b0;
  logic cmd_ready_r, rsp_valid_r, prog_rd_r, power_down_r, wdt_wake_r, wdt_reset_r;
  logic [7:0] rsp_data_r, acc_r, status_r;
  logic [10:0] prog_addr_r;
  int err_total = 0;
  int comparisons = 0;
  integer seed = 32'h8b622cf0;
  logic b2b = 1'b0;
  logic to_e = 1'b0;
  logic pdf_e = 1'b0;
  logic [3:0] lo_e = 4'h0;
  logic [7:0] dq[$];
  logic [10:0] aq[$];

  // Free-running 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  mds_core uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_fn(cmd_fn), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_imm(cmd_imm),
    .cmd_to_acc(cmd_to_acc), .pc_now(pc_now), .prog_data(prog_data),
    .wdt_timeout(wdt_timeout), .cmd_ready_r(cmd_ready_r), .rsp_valid_r(rsp_valid_r),
    .rsp_data_r(rsp_data_r), .prog_rd_r(prog_rd_r), .prog_addr_r(prog_addr_r),
    .acc_r(acc_r), .status_r(status_r), .power_down_r(power_down_r),
    .wdt_wake_r(wdt_wake_r), .wdt_reset_r(wdt_reset_r));

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  // Shared tally: every comparison counted, a mismatch reported at once
  task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (!ok)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, 16'(got), 16'(exp));
  endtask
  task automatic cmpa(input logic [10:0] got, input logic [10:0] exp);
    tally(got === exp, 16'(got), 16'(exp));
  endtask
  task automatic chk1(input logic got, input logic exp);
    tally(got === exp, 16'(got), 16'(exp));
  endtask

  // One command; b2b keeps the strobe up so the next one follows at once
  task automatic issue(input mds_pkg::mds_op_e op, input logic [7:0] addr,
    input logic [7:0] data, input mds_pkg::mds_fn_e fn = mds_pkg::FN_ADD,
    input logic imm = 1'b0, input logic to_a = 1'b1);
    int n;
    n = 0;
    while (cmd_ready_r !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmd_op = op;
    cmd_fn = fn;
    cmd_addr = addr;
    cmd_data = data;
    cmd_imm = imm;
    cmd_to_acc = to_a;
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    if (!b2b)
    begin
      cmd_valid = 1'b0;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    issue(mds_pkg::OP_WR, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    dq.push_back(e);
    issue(mds_pkg::OP_RD, a, 8'($random(seed)));
  endtask
  task automatic rdst();
    cmp8(status_r, {2'b00, to_e, pdf_e, lo_e});
    rd(mds_pkg::ADDR_STAT, {2'b00, to_e, pdf_e, lo_e});
  endtask

  // Table read; the ROM word is offered from the fetch cycle on and left in place
  task automatic tbl(input mds_pkg::mds_op_e op, input logic [7:0] dst,
    input logic [15:0] w, input logic [10:0] ea);
    aq.push_back(ea);
    dq.push_back(w[7:0]);
    b2b = 1'b1;
    issue(op, dst, 8'h00);
    prog_data = w;
    chk1(cmd_ready_r, 1'b0);
    b2b = 1'b0;
  endtask

  // Time-out pulse; wakes when halted, asks for reset when running
  task automatic pulse_timeout(input logic wake);
    wdt_timeout = 1'b1;
    @(posedge sys_clk);
    #1;
    wdt_timeout = 1'b0;
    chk1(wdt_wake_r, wake);
    chk1(wdt_reset_r, !wake);
    chk1(power_down_r, 1'b0);
    to_e = 1'b1;
  endtask

  // Adder model: result, then signed wrap, zero, nibble carry, carry
  function automatic logic [11:0] arith(input mds_pkg::mds_fn_e f, input logic [7:0] a,
    input logic [7:0] b, input logic c);
    logic [7:0] bb;
    logic ci;
    logic [4:0] n;
    logic [8:0] s;
    logic [7:0] l7;
    bb = (f == mds_pkg::FN_SUB || f == mds_pkg::FN_SBC) ? ~b : b;
    ci = (f == mds_pkg::FN_SUB) ? 1'b1 : (f == mds_pkg::FN_ADD) ? 1'b0 : c;
    n = a[3:0] + bb[3:0] + ci;
    s = a + bb + ci;
    l7 = a[6:0] + bb[6:0] + ci;
    return {s[7:0], l7[7] ^ s[8], s[7:0] == 8'h00, n[4], s[8]};
  endfunction

  // Response watcher: answers are settled by the falling edge
  always @(negedge sys_clk)
  begin
    if (rsp_valid_r === 1'b1)
      cmp8(rsp_data_r, dq.size() ? dq.pop_front() : 8'hxx);
    if (prog_rd_r === 1'b1)
      cmpa(prog_addr_r, aq.size() ? aq.pop_front() : 11'hxxx);
  end

  task automatic complete_run();
    if (dq.size() != 0 || aq.size() != 0)
      err_total++;
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard: the sequence needs well under a thousand cycles
  initial
  begin
    #(100 * 5000);
    err_total++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0] d, e, a, b;
    logic [11:0] r;
    logic [15:0] w;
    logic [7:0] rw[4];
    logic [7:0] un[6];
    mds_pkg::mds_fn_e fns[4];
    rw = '{8'h01, 8'h03, 8'h05, 8'h07};
    un = '{8'h04, 8'h06, 8'h09, 8'h0b, 8'h7f, 8'he0};
    fns = '{mds_pkg::FN_ADD, mds_pkg::FN_ADC, mds_pkg::FN_SUB, mds_pkg::FN_SBC};
    repeat (20) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    // Reset values, then read/write registers and unused places
    foreach (rw[i]) rd(rw[i], 8'h00);
    rd(mds_pkg::ADDR_TABLE_HIGH_BYTE, 8'h00);
    rdst();
    foreach (rw[i])
    begin
      d = 8'($random(seed));
      wr(rw[i], d);
      rd(rw[i], d);
    end
    foreach (un[i])
    begin
      wr(un[i], 8'($random(seed)));
      rd(un[i], 8'h00);
    end
    d = 8'($random(seed));
    wr(8'h80, d);
    wr(8'hdf, ~d);
    rd(8'h80, d);
    rd(8'hdf, ~d);
    // Indirect windows, loops through a window and display reach
    d = 8'($random(seed));
    e = 8'($random(seed));
    wr(mds_pkg::ADDR_PTR0, 8'h85);
    wr(mds_pkg::ADDR_WIN0, d);
    rd(8'h85, d);
    rd(mds_pkg::ADDR_WIN0, d);
    wr(mds_pkg::ADDR_PTR1, 8'h86);
    wr(mds_pkg::ADDR_WIN1, e);
    rd(8'h86, e);
    wr(mds_pkg::ADDR_PTR0, mds_pkg::ADDR_WIN1);
    wr(mds_pkg::ADDR_WIN0, ~e);
    rd(mds_pkg::ADDR_WIN0, 8'h00);
    rd(8'h86, e);
    wr(mds_pkg::ADDR_PTR1, mds_pkg::DISP_BASE);
    wr(mds_pkg::ADDR_WIN1, d);
    rd(mds_pkg::ADDR_WIN1, d);
    rd(mds_pkg::DISP_BASE, 8'h00);
    wr(mds_pkg::ADDR_PTR0, mds_pkg::DISP_BASE);
    rd(mds_pkg::ADDR_WIN0, 8'h00);
    // Table reads, each followed at once by a read
    w = 16'($random(seed));
    d = 8'($random(seed));
    pc_now = 11'($random(seed));
    wr(mds_pkg::ADDR_TABLE_POINTER, d);
    tbl(mds_pkg::OP_TRC, 8'h88, w, {pc_now[10:8], d});
    rd(mds_pkg::ADDR_TABLE_HIGH_BYTE, w[15:8]);
    rd(8'h88, w[7:0]);
    w = 16'($random(seed));
    tbl(mds_pkg::OP_TRL, 8'h89, w, {3'b111, d});
    rd(8'h89, w[7:0]);
    wr(mds_pkg::ADDR_TABLE_HIGH_BYTE, ~w[15:8]);
    rd(mds_pkg::ADDR_TABLE_HIGH_BYTE, w[15:8]);
    // Arithmetic flags, starting from the wrap and zero corner
    foreach (fns[i])
    begin
      for (int k = 0; k < 5; k++)
      begin
        a = (k == 0) ? 8'h80 : 8'($random(seed));
        b = (k == 0) ? 8'h80 : 8'($random(seed));
        r = arith(fns[i], a, b, lo_e[0]);
        wr(mds_pkg::ADDR_ACC, a);
        issue(mds_pkg::OP_ALU, 8'h00, b, fns[i], 1'b1);
        cmp8(acc_r, r[11:4]);
        lo_e = r[3:0];
        rd(mds_pkg::ADDR_ACC, r[11:4]);
        rdst();
      end
    end
    // Increment back to memory, then rotates through carry
    wr(8'h91, 8'hff);
    issue(mds_pkg::OP_ALU, 8'h91, 8'h00, mds_pkg::FN_INC, 1'b0, 1'b0);
    lo_e[2] = 1'b1;
    rd(8'h91, 8'h00);
    b = 8'($random(seed));
    issue(mds_pkg::OP_ALU, 8'h00, b, mds_pkg::FN_RLC, 1'b1);
    rd(mds_pkg::ADDR_ACC, {b[6:0], lo_e[0]});
    lo_e[0] = b[7];
    issue(mds_pkg::OP_ALU, 8'h00, b, mds_pkg::FN_RRC, 1'b1);
    rd(mds_pkg::ADDR_ACC, {lo_e[0], b[7:1]});
    lo_e[0] = b[0];
    rdst();
    // Logic ops and decrement move only the zero flag
    a = (8'($random(seed)) & 8'h7f) | 8'h01;
    wr(mds_pkg::ADDR_ACC, a);
    issue(mds_pkg::OP_ALU, 8'h00, ~a, mds_pkg::FN_AND, 1'b1);
    cmp8(acc_r, 8'h00);
    issue(mds_pkg::OP_ALU, 8'h00, a, mds_pkg::FN_OR, 1'b1);
    cmp8(acc_r, a);
    issue(mds_pkg::OP_ALU, 8'h00, a, mds_pkg::FN_XOR, 1'b1);
    cmp8(acc_r, 8'h00);
    issue(mds_pkg::OP_ALU, 8'h00, a, mds_pkg::FN_CPL, 1'b1);
    cmp8(acc_r, ~a);
    issue(mds_pkg::OP_ALU, 8'h00, 8'h01, mds_pkg::FN_DEC, 1'b1);
    lo_e[2] = 1'b1;
    rdst();
    // Bit set and clear over every position
    d = 8'($random(seed));
    wr(8'h90, d);
    for (int i = 0; i < 8; i++)
    begin
      issue(mds_pkg::OP_BSET, 8'h90, 8'(i));
      d[i] = 1'b1;
      issue(mds_pkg::OP_BCLR, 8'h90, 8'(7 - i));
      d[7 - i] = 1'b0;
      rd(8'h90, d);
    end
    // Status store keeps the watchdog flags, top bits read zero
    wr(mds_pkg::ADDR_STAT, 8'hff);
    lo_e = 4'hf;
    rdst();
    // Halt, wake by time-out, kick, running time-out, halt again
    issue(mds_pkg::OP_SYS, 8'h00, 8'h00, mds_pkg::FN_HALT);
    pdf_e = 1'b1;
    chk1(power_down_r, 1'b1);
    pulse_timeout(1'b1);
    wr(mds_pkg::ADDR_STAT, 8'h00);
    lo_e = 4'h0;
    rdst();
    issue(mds_pkg::OP_SYS, 8'h00, 8'h00, mds_pkg::FN_KICK);
    to_e = 1'b0;
    pdf_e = 1'b0;
    rdst();
    pulse_timeout(1'b0);
    rdst();
    issue(mds_pkg::OP_SYS, 8'h00, 8'h00, mds_pkg::FN_HALT);
    to_e = 1'b0;
    pdf_e = 1'b1;
    rdst();
    repeat (3) @(posedge sys_clk);
    complete_run();
  end
endmodule
`default_nettype wire
